//--- rtl/rfc_core.sv
// rfc_core: reference and feedback combiner with wishbone registers
// assumes a classic wishbone master on clk_sys; all inputs synchronous
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rfc_regs.svh"
module rfc_core #(
	parameter int unsigned DP_STEP_CYC = `RFC_DP_CYC
) (
	input  wire logic              clk_sys,     // system clock
	input  wire logic              reset,       // sync reset, high
	input  wire logic              wb_cyc_i,    // bus cycle
	input  wire logic              wb_stb_i,    // bus strobe
	input  wire logic              wb_we_i,     // bus write
	input  wire logic [7:0]        wb_adr_i,    // byte address
	input  wire logic [3:0]        wb_sel_i,    // byte lanes
	input  wire logic [31:0]       wb_dat_i,    // write data
	output var  logic [31:0]       wb_dat_o,    // read data
	output var  logic              wb_ack_o,    // bus ack
	input  wire rfc_pkg::rfc_ext_s ext_in,      // external refs
	input  wire logic [2:0]        preset_code, // preset pick
	input  wire rfc_pkg::rfc_dpot_s dpot,       // digipot keys
	input  wire rfc_pkg::rfc_fb_s  fb_in,       // sensor feedback
	output var  rfc_pkg::rfc_val_t ref_out,     // scaled ref
	output var  rfc_pkg::rfc_val_t sp_out,      // setpoint
	output var  rfc_pkg::rfc_val_t fb_out,      // feedback
	output var  logic [1:0]        pair_idx,    // chosen zone
	output var  logic              integ_en,    // integral on
	output var  logic              deriv_en     // derivative on
);
	localparam int W = `RFC_W;
	localparam logic signed [35:0] VMAX = (36'sd1 <<< (W - 1)) - 36'sd1;
	localparam logic signed [35:0] VMIN = -(36'sd1 <<< (W - 1));

	logic [1:0]        ref_mode;
	logic              pre_bus;
	logic [2:0]        pre_sel;
	rfc_pkg::rfc_val_t scale_y, bus_ref, digipot;
	logic [8:0]        src_sel;
	logic [4:0]        fb_fn;
	logic              sqrt_en, three_fb;
	logic [2:0]        lpf_sh;
	rfc_pkg::rfc_val_t sp [3];
	logic [15:0]       itime, dtime;
	logic              wb_ph;
	logic [31:0]       rd_mux, wdat, wmask;
	logic              wr_go, pre_we;
	rfc_pkg::rfc_val_t pre_rd_a, pre_rd_b;
	rfc_pkg::rfc_val_t fb_raw [3], fb_sq [3], fl [3];
	rfc_pkg::rfc_val_t ext_tot, act_ref, scaled;
	rfc_pkg::rfc_val_t next_sp, next_fb;
	logic [1:0]        next_pair, best, nfb;
	logic signed [W:0] dif [3];
	logic signed [35:0] fsum;
	rfc_pkg::rfc_zone_e zone;
	logic [31:0]       dp_cnt;

	// clip a wide value into the common format
	function automatic rfc_pkg::rfc_val_t sat(input logic signed [35:0] v);
		if (v > VMAX) begin
			return VMAX[W-1:0];
		end else if (v < VMIN) begin
			return VMIN[W-1:0];
		end
		return v[W-1:0];
	endfunction

	// value of one external source selector
	function automatic rfc_pkg::rfc_val_t src_val(input logic [2:0] c);
		case (c)
			`RFC_SRC_AIN1: return ext_in.ain1;
			`RFC_SRC_AIN2: return ext_in.ain2;
			`RFC_SRC_PULS: return ext_in.pulse;
			`RFC_SRC_DPOT: return digipot;
			default:       return '0;
		endcase
	endfunction

	// bus handshake: decode cycle, then ack with registered data
	assign wr_go  = wb_ph && wb_cyc_i && wb_stb_i && wb_we_i;
	assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat   = (rd_mux & ~wmask) | (wb_dat_i & wmask);
	assign pre_we = wr_go && (wb_adr_i[7:5] == `RFC_PRE_HI);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wb_ph    <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ph    <= wb_cyc_i && wb_stb_i && !wb_ph && !wb_ack_o;
			wb_ack_o <= wb_ph && wb_cyc_i && wb_stb_i;
			wb_dat_o <= (wb_ph && !wb_we_i) ? rd_mux : 32'h0;
		end
	end

	// readback mux, unmapped words read zero
	always_comb begin
		rd_mux = 32'h0;
		case (wb_adr_i)
			`RFC_CTRL:    rd_mux = {29'h0, pre_bus, ref_mode};
			`RFC_PSEL:    rd_mux = {29'h0, pre_sel};
			`RFC_SCALE:   rd_mux = 32'(scale_y);
			`RFC_BUSREF:  rd_mux = 32'(bus_ref);
			`RFC_SRCSEL:  rd_mux = {23'h0, src_sel};
			`RFC_FBFN:    rd_mux = {21'h0, lpf_sh, 1'b0, three_fb,
				sqrt_en, fb_fn};
			`RFC_SP1:     rd_mux = 32'(sp[0]);
			`RFC_SP2:     rd_mux = 32'(sp[1]);
			`RFC_SP3:     rd_mux = 32'(sp[2]);
			`RFC_ITIME:   rd_mux = {16'h0, itime};
			`RFC_DTIME:   rd_mux = {16'h0, dtime};
			`RFC_STATUS:  rd_mux = {28'h0, pair_idx, deriv_en, integ_en};
			`RFC_REFOUT:  rd_mux = 32'(ref_out);
			`RFC_FBOUT:   rd_mux = 32'(fb_out);
			`RFC_DIGIPOT: rd_mux = 32'(digipot);
			default: begin
				if (wb_adr_i[7:5] == `RFC_PRE_HI) begin
					rd_mux = 32'(pre_rd_b);
				end
			end
		endcase
	end

	// software settings
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ref_mode <= `RFC_REF_EXT;
			pre_bus  <= 1'b0;
			pre_sel  <= 3'h0;
			scale_y  <= '0;
			bus_ref  <= '0;
			src_sel  <= 9'h000;
			fb_fn    <= 5'h00;
			sqrt_en  <= 1'b0;
			three_fb <= 1'b0;
			lpf_sh   <= 3'h0;
			sp       <= '{default: '0};
			itime    <= `RFC_ITIME_OFF;
			dtime    <= `RFC_DTIME_OFF;
		end else if (wr_go) begin
			case (wb_adr_i)
				`RFC_CTRL:   {pre_bus, ref_mode} <= wdat[2:0];
				`RFC_PSEL:   pre_sel <= wdat[2:0];
				`RFC_SCALE:  scale_y <= wdat[W-1:0];
				`RFC_BUSREF: bus_ref <= wdat[W-1:0];
				`RFC_SRCSEL: src_sel <= wdat[8:0];
				`RFC_FBFN: begin
					fb_fn    <= wdat[4:0];
					sqrt_en  <= wdat[5];
					three_fb <= wdat[6];
					lpf_sh   <= wdat[10:8];
				end
				`RFC_SP1:    sp[0] <= wdat[W-1:0];
				`RFC_SP2:    sp[1] <= wdat[W-1:0];
				`RFC_SP3:    sp[2] <= wdat[W-1:0];
				`RFC_ITIME:  itime <= wdat[15:0];
				`RFC_DTIME:  dtime <= wdat[15:0];
				default: ;
			endcase
		end
	end

	// preset store, active entry from input code or bus register
	rfc_preset_mem #(
		.DEPTH (`RFC_NPRE),
		.AW    (3)
	) u_pre (
		.clk_sys (clk_sys),
		.reset   (reset),
		.we      (pre_we),
		.waddr   (wb_adr_i[4:2]),
		.wdata   (wdat[W-1:0]),
		.raddr_a (pre_bus ? pre_sel : preset_code),
		.rdata_a (pre_rd_a),
		.raddr_b (wb_adr_i[4:2]),
		.rdata_b (pre_rd_b)
	);

	// digipot: clear wins, then one step per period
	always_ff @(posedge clk_sys) begin
		if (reset || dpot.clr) begin
			digipot <= `RFC_DP_RST;
			dp_cnt  <= 32'h0;
		end else if (dp_cnt == DP_STEP_CYC - 1) begin
			dp_cnt <= 32'h0;
			if (dpot.up && !dpot.down) begin
				digipot <= sat(36'(digipot) + 36'(`RFC_DP_STEP));
			end else if (dpot.down && !dpot.up) begin
				digipot <= sat(36'(digipot) - 36'(`RFC_DP_STEP));
			end
		end else begin
			dp_cnt <= dp_cnt + 32'h1;
		end
	end

	// reference path: sources, active choice, percent scaling
	always_comb begin
		ext_tot = sat(36'(src_val(src_sel[2:0])) +
			36'(src_val(src_sel[5:3])) + 36'(src_val(src_sel[8:6])) +
			36'(bus_ref));
		case (ref_mode)
			`RFC_REF_PRE: act_ref = pre_rd_a;
			`RFC_REF_SUM: act_ref = sat(36'(ext_tot) + 36'(pre_rd_a));
			default:      act_ref = ext_tot;
		endcase
		// zero percent adds exactly zero
		scaled = sat(36'(act_ref) +
			(36'(act_ref) * 36'(scale_y)) / `RFC_PCT);
	end

	// feedback conversion and low-pass, time constant 2^lpf_sh cycles
	assign fb_raw[0] = fb_in.fb1;
	assign fb_raw[1] = fb_in.fb2;
	assign fb_raw[2] = fb_in.fb3;
	for (genvar k = 0; k < 3; k++) begin : g_fb
		logic signed [W:0] err;
		rfc_sqrt #(
			.W    (W),
			.FRAC (`RFC_FRAC)
		) u_sq (
			.clk_sys (clk_sys),
			.reset   (reset),
			.din     (fb_raw[k]),
			.dout    (fb_sq[k])
		);
		assign err = (W+1)'(sqrt_en ? fb_sq[k] : fb_raw[k]) -
			(W+1)'(fl[k]);
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				fl[k] <= '0;
			end else begin
				fl[k] <= W'((W+1)'(fl[k]) + (err >>> lpf_sh));
			end
		end
		assign dif[k] = (W+1)'(sp[k]) - (W+1)'(fl[k]);
	end

	// zone decode from feedback function code
	always_comb begin
		if (fb_fn == `RFC_FN_MSMIN || fb_fn == `RFC_FN_MSMAX) begin
			zone = rfc_pkg::RFC_ZONE_MULTI_SP;
		end else if (fb_fn >= `RFC_FN_SUM && fb_fn <= `RFC_FN_MAX) begin
			zone = rfc_pkg::RFC_ZONE_MULTI_SP1;
		end else begin
			zone = rfc_pkg::RFC_ZONE_SINGLE;
		end
	end

	// setpoint and feedback selection
	assign nfb  = three_fb ? 2'h3 : 2'h2;
	assign fsum = 36'(fl[0]) + 36'(fl[1]) + (three_fb ? 36'(fl[2]) : 36'sh0);
	always_comb begin
		next_pair = 2'h0;
		next_sp   = sp[0];
		next_fb   = fl[0];
		best      = 2'h0;
		case (zone)
			rfc_pkg::RFC_ZONE_SINGLE: begin
				next_sp = sat(36'(scaled) + 36'(sp[0]));
				if (fb_fn == `RFC_FN_FB2) begin
					next_fb = fl[1];
				end else if (fb_fn == `RFC_FN_FB3) begin
					next_fb = fl[2];
				end
			end
			rfc_pkg::RFC_ZONE_MULTI_SP1: begin
				case (fb_fn)
					`RFC_FN_SUM:  next_fb = sat(fsum);
					`RFC_FN_DIFF: next_fb = sat(36'(fl[0]) - 36'(fl[1]));
					`RFC_FN_AVG:  next_fb = sat(fsum /
						(three_fb ? 36'sh3 : 36'sh2));
					default: begin
						for (int k = 1; k < 3; k++) begin
							if (k < nfb && ((fb_fn == `RFC_FN_MIN) ?
								fl[k] < fl[best] : fl[k] > fl[best])) begin
								best = 2'(k);
							end
						end
						next_fb = fl[best];
					end
				endcase
			end
			rfc_pkg::RFC_ZONE_MULTI_SP: begin
				for (int k = 1; k < 3; k++) begin
					if (k < nfb && ((fb_fn == `RFC_FN_MSMAX) ?
						dif[k] < dif[best] :
						dif[k] > dif[best])) begin
						best = 2'(k);
					end
				end
				next_pair = best;
				next_sp   = sp[best];
				next_fb   = fl[best];
			end
			default: ;
		endcase
	end

	// registered outputs to the controller
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ref_out  <= '0;
			sp_out   <= '0;
			fb_out   <= '0;
			pair_idx <= 2'h0;
			integ_en <= 1'b0;
			deriv_en <= 1'b0;
		end else begin
			ref_out  <= scaled;
			sp_out   <= next_sp;
			fb_out   <= next_fb;
			pair_idx <= next_pair;
			integ_en <= itime != `RFC_ITIME_OFF;
			deriv_en <= dtime != `RFC_DTIME_OFF;
		end
	end

	// checks on the datapath
	logic signed [W:0] d_out;
	assign d_out = (W+1)'(sp_out) - (W+1)'(fb_out);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_dp_clear;
		dpot.clr ##1 !dpot.clr;
	endsequence
	property p_dp_clear;
		s_dp_clear |-> digipot == `RFC_DP_RST;
	endproperty
	a_dp_clear: assert property (p_dp_clear)
		else $error("digipot not cleared");

	property p_dp_up;
		(dpot.up && !dpot.down && !dpot.clr && dp_cnt == DP_STEP_CYC - 1 &&
			36'(digipot) < VMAX) |=> digipot == $past(digipot) + `RFC_DP_STEP;
	endproperty
	a_dp_up: assert property (p_dp_up)
		else $error("digipot did not step up");

	property p_scale0;
		scale_y == '0 |=> ref_out == $past(act_ref);
	endproperty
	a_scale0: assert property (p_scale0)
		else $error("zero scaling changed reference");

	property p_itime;
		(itime == `RFC_ITIME_OFF) [*2] |-> !integ_en;
	endproperty
	a_itime: assert property (p_itime)
		else $error("integral not off");

	property p_dtime;
		$changed(dtime) |=> integ_en == $past(itime != `RFC_ITIME_OFF) &&
			deriv_en == $past(dtime != `RFC_DTIME_OFF);
	endproperty
	a_dtime: assert property (p_dtime)
		else $error("derivative enable wrong");

	property p_msmax;
		fb_fn == `RFC_FN_MSMAX |=> d_out <= $past(dif[0]) &&
			d_out <= $past(dif[1]) && (d_out <= $past(dif[2]) ||
			!$past(three_fb));
	endproperty
	a_msmax: assert property (p_msmax)
		else $error("pair not smallest difference");

	property p_msmin;
		fb_fn == `RFC_FN_MSMIN |=> d_out >= $past(dif[0]) &&
			d_out >= $past(dif[1]) && (d_out >= $past(dif[2]) ||
			!$past(three_fb));
	endproperty
	a_msmin: assert property (p_msmin)
		else $error("pair not largest difference");

	property p_reset;
		@(posedge clk_sys) disable iff (1'b0)
		reset |=> ref_out == '0 && sp_out == '0 && fb_out == '0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not zero after reset");
endmodule
`default_nettype wire

//--- rtl/rfc_pkg.sv
// rfc_pkg: value type and carrier structs of the combiner
// assumes rfc_regs.svh is on the include path
`include "rfc_regs.svh"
package rfc_pkg;
	typedef logic signed [`RFC_W-1:0] rfc_val_t;
	typedef struct packed {
		rfc_val_t ain1;
		rfc_val_t ain2;
		rfc_val_t pulse;
	} rfc_ext_s;
	typedef struct packed {
		rfc_val_t fb1;
		rfc_val_t fb2;
		rfc_val_t fb3;
	} rfc_fb_s;
	typedef struct packed {
		logic up;
		logic down;
		logic clr;
	} rfc_dpot_s;
	typedef enum logic [1:0] {
		RFC_ZONE_SINGLE,
		RFC_ZONE_MULTI_SP1,
		RFC_ZONE_MULTI_SP
	} rfc_zone_e;
endpackage

//--- rtl/rfc_preset_mem.sv
// rfc_preset_mem: preset reference store, one write and two read ports
// assumes one clock; read data registered, one cycle after the address
`timescale 1ns/10ps
`default_nettype none
module rfc_preset_mem #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic              clk_sys, // system clock
	input  wire logic              reset,   // sync reset, high
	input  wire logic              we,      // write strobe
	input  wire logic [AW-1:0]     waddr,   // write index
	input  wire rfc_pkg::rfc_val_t wdata,   // write value
	input  wire logic [AW-1:0]     raddr_a, // datapath index
	output var  rfc_pkg::rfc_val_t rdata_a, // datapath value
	input  wire logic [AW-1:0]     raddr_b, // bus index
	output var  rfc_pkg::rfc_val_t rdata_b  // bus value
);
	rfc_pkg::rfc_val_t mem [DEPTH];

	// store, cleared on reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered reads
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			rdata_a <= mem[raddr_a];
			rdata_b <= mem[raddr_b];
		end
	end
endmodule
`default_nettype wire

//--- rtl/rfc_regs.svh
// rfc_regs.svh: offsets, fields, codes and timing counts of the combiner
// assumes a 32-bit wishbone word per register, byte addresses below
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH
// value format: signed fixed point, FRAC fraction bits
`define RFC_W        16
`define RFC_FRAC     8
`define RFC_NPRE     8
// register byte addresses
`define RFC_CTRL     8'h00
`define RFC_PSEL     8'h04
`define RFC_SCALE    8'h08
`define RFC_BUSREF   8'h0C
`define RFC_SRCSEL   8'h10
`define RFC_FBFN     8'h14
`define RFC_SP1      8'h18
`define RFC_SP2      8'h1C
`define RFC_SP3      8'h20
`define RFC_ITIME    8'h24
`define RFC_DTIME    8'h28
`define RFC_STATUS   8'h2C
`define RFC_REFOUT   8'h30
`define RFC_FBOUT    8'h34
`define RFC_DIGIPOT  8'h38
`define RFC_PRE_HI   3'h2
// active reference choice, ctrl[1:0]
`define RFC_REF_EXT  2'h0
`define RFC_REF_PRE  2'h1
`define RFC_REF_SUM  2'h2
// external source codes, three 3-bit fields
`define RFC_SRC_AIN1 3'h1
`define RFC_SRC_AIN2 3'h2
`define RFC_SRC_PULS 3'h3
`define RFC_SRC_DPOT 3'h4
// feedback function codes, fbfn[4:0]
`define RFC_FN_FB2   5'h01
`define RFC_FN_FB3   5'h02
`define RFC_FN_SUM   5'h03
`define RFC_FN_DIFF  5'h04
`define RFC_FN_AVG   5'h05
`define RFC_FN_MIN   5'h06
`define RFC_FN_MAX   5'h07
`define RFC_FN_MSMIN 5'h0D
`define RFC_FN_MSMAX 5'h0E
// controller time settings that mean off
`define RFC_ITIME_OFF 16'h2710
`define RFC_DTIME_OFF 16'h0000
// scaling divisor, percent
`define RFC_PCT      36'sh64
// digipot: reset value, step, step period
`define RFC_DP_RST   16'h0000
`define RFC_DP_STEP  16'h0001
`define RFC_CLK_MHZ  50
`define RFC_DP_US    1000
`define RFC_DP_CYC   (`RFC_DP_US * `RFC_CLK_MHZ)
`endif

//--- rtl/rfc_sqrt.sv
// rfc_sqrt: square root of a fixed-point feedback value
// assumes non-negative inputs; negative reads as zero, result registered
`timescale 1ns/10ps
`default_nettype none
module rfc_sqrt #(
	parameter int W    = 16,
	parameter int FRAC = 8
) (
	input  wire logic                clk_sys, // system clock
	input  wire logic                reset,   // sync reset, high
	input  wire logic signed [W-1:0] din,     // value in
	output var  logic signed [W-1:0] dout     // root out
);
	// bitwise root of din scaled up so the result keeps FRAC bits
	function automatic logic [W-1:0] root(input logic signed [W-1:0] x);
		logic [2*W-1:0] v;
		logic [W-1:0]   r;
		logic [W-1:0]   t;
		v = '0;
		r = '0;
		t = '0;
		if (!x[W-1]) begin
			v = (2*W)'(x) << FRAC;
		end
		for (int i = W - 1; i >= 0; i--) begin
			t = r | (W'(1) << i);
			if ((2*W)'(t) * (2*W)'(t) <= v) begin
				r = t;
			end
		end
		return r;
	endfunction

	// one cycle of latency
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dout <= '0;
		end else begin
			dout <= root(din);
		end
	end
endmodule
`default_nettype wire

//--- verif/rfc_far.sv
// rfc_far: model of the analog, pulse, key and sensor inputs of the core
// assumes the bench sets wanted levels just after an edge
`timescale 1ns/10ps
`default_nettype none
module rfc_far (
	input  wire logic               clk_sys,     // system clock
	input  wire rfc_pkg::rfc_ext_s  ext_set,     // wanted source levels
	input  wire logic [2:0]         code_set,    // wanted preset code
	input  wire rfc_pkg::rfc_dpot_s key_set,     // wanted key levels
	input  wire rfc_pkg::rfc_fb_s   fb_set,      // wanted sensor levels
	output var  rfc_pkg::rfc_ext_s  ext_in,      // external refs
	output var  logic [2:0]         preset_code, // preset pick
	output var  rfc_pkg::rfc_dpot_s dpot,        // digipot keys
	output var  rfc_pkg::rfc_fb_s   fb_in        // sensor feedback
);
	// input front end: levels reach the core one edge after being set
	always_ff @(posedge clk_sys) begin
		ext_in      <= ext_set;
		preset_code <= code_set;
		dpot        <= key_set;
		fb_in       <= fb_set;
	end
endmodule
`default_nettype wire

//--- verif/tb.sv
// tb: drives the combiner over wishbone and checks its datapath outputs
// assumes rfc_core with a short digipot step and the rfc_far model
`timescale 1ns/10ps
`default_nettype none
`include "rfc_regs.svh"
module tb;
	logic               clk_sys;  // system clock
	logic               reset;    // sync reset
	logic               cyc;      // bus cycle and strobe
	logic               we;       // bus write
	logic [7:0]         adr;      // byte address
	logic [31:0]        wdat;     // write data
	logic [31:0]        rdat;     // read data
	logic               ack;      // bus ack
	logic [31:0]        q;        // last read word
	logic [3:0]         sel;      // byte lanes
	rfc_pkg::rfc_ext_s  ext_set;  // wanted source levels
	logic [2:0]         code_set; // wanted preset code
	rfc_pkg::rfc_dpot_s key_set;  // wanted key levels
	rfc_pkg::rfc_fb_s   fb_set;   // wanted sensor levels
	rfc_pkg::rfc_ext_s  ext;      // external refs
	logic [2:0]         pcode;    // preset code
	rfc_pkg::rfc_dpot_s keyv;     // digipot keys
	rfc_pkg::rfc_fb_s   fbv;      // feedbacks
	rfc_pkg::rfc_val_t  ref_out;  // scaled ref
	rfc_pkg::rfc_val_t  sp_out;   // setpoint
	rfc_pkg::rfc_val_t  fb_out;   // feedback
	logic [1:0]         pair_idx; // chosen zone
	logic               integ_en; // integral on
	logic               deriv_en; // derivative on
	int                 mismatches;
	int                 num_checks;
	int                 i;
	logic [4:0] fn [5] = '{`RFC_FN_SUM, `RFC_FN_DIFF, `RFC_FN_AVG,
		`RFC_FN_MIN, `RFC_FN_MAX};
	logic [15:0] fx [5] = '{16'h0400, 16'h0200, 16'h0200, 16'h0100,
		16'h0300};
	// device under test, digipot step shortened to 4 cycles
	rfc_core #(.DP_STEP_CYC(4)) rfc_core_inst (.clk_sys(clk_sys),
		.reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .ext_in(ext),
		.preset_code(pcode), .dpot(keyv), .fb_in(fbv),
		.ref_out(ref_out), .sp_out(sp_out), .fb_out(fb_out),
		.pair_idx(pair_idx), .integ_en(integ_en), .deriv_en(deriv_en));
	// far side inputs
	rfc_far rfc_far_inst (.clk_sys(clk_sys), .ext_set(ext_set),
		.code_set(code_set), .key_set(key_set), .fb_set(fb_set),
		.ext_in(ext), .preset_code(pcode), .dpot(keyv), .fb_in(fbv));
	// 50 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic close_out();
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic fail(input string m);
		mismatches++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e)
			fail($sformatf("got %h want %h", g, e));
	endtask
	task automatic rng(input logic [15:0] g, input logic [15:0] lo, hi);
		num_checks++;
		if ((g >= lo && g <= hi) !== 1'b1)
			fail($sformatf("got %h outside %h..%h", g, lo, hi));
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		if (n >= 50) begin
			fail("bus timeout");
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		chk(q[15:0], e);
	endtask
	task automatic settle();
		repeat (8) @(posedge clk_sys);
	endtask
	// far side levels change just after an edge
	task automatic set_ext(input rfc_pkg::rfc_val_t a, b, c);
		@(posedge clk_sys);
		ext_set <= {a, b, c};
	endtask
	task automatic set_fb(input rfc_pkg::rfc_val_t a, b, c);
		@(posedge clk_sys);
		fb_set <= {a, b, c};
	endtask
	task automatic set_code(input logic [2:0] c);
		@(posedge clk_sys);
		code_set <= c;
	endtask
	// up, down and clear keys as levels
	task automatic keys(input logic [2:0] k);
		@(posedge clk_sys);
		key_set <= k;
	endtask
	// main sequence
	initial begin
		mismatches = 0;
		num_checks = 0;
		reset = 1'b1;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		ext_set = '0;
		code_set = 3'h0;
		key_set = '0;
		fb_set = '0;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		settle();
		chk({14'h0, integ_en, deriv_en}, 16'h0000);
		chk(ref_out, 16'h0000);
		rd(`RFC_ITIME, 16'h2710);
		wr(`RFC_ITIME, 32'h5);
		wr(`RFC_DTIME, 32'h3);
		settle();
		rd(`RFC_STATUS, 16'h0003);
		wr(`RFC_ITIME, 32'h2710);
		wr(`RFC_DTIME, 32'h0);
		wr(`RFC_STATUS, 32'h3);
		settle();
		rd(`RFC_STATUS, 16'h0000);
		rd(8'h3C, 16'h0000);
		set_ext(16'h0100, 16'h0080, 16'h0040);
		wr(`RFC_SRCSEL, 32'h0D1);
		wr(`RFC_BUSREF, 32'h20);
		settle();
		chk(ref_out, 16'h01E0);
		wr(`RFC_SCALE, 32'h32);
		settle();
		chk(ref_out, 16'h02D0);
		wr(`RFC_SCALE, 32'hFFFF_FFE7);
		settle();
		rd(`RFC_REFOUT, 16'h0168);
		wr(`RFC_SCALE, 32'h0);
		set_ext(16'h7000, 16'h7000, 16'h0000);
		settle();
		chk(ref_out, 16'h7FFF);
		set_ext(16'h9000, 16'h9000, 16'h0000);
		settle();
		chk(ref_out, 16'h8000);
		set_ext(16'h0100, 16'h0080, 16'h0040);
		wr(8'h4C, 32'h0123);
		wr(8'h54, 32'h0456);
		wr(8'h5C, 32'h0777);
		rd(8'h5C, 16'h0777);
		wb(1'b1, 8'h5C, 32'h0000_0099, 4'h1);
		rd(8'h5C, 16'h0799);
		wr(`RFC_PSEL, 32'h3);
		wr(`RFC_CTRL, 32'h5);
		settle();
		chk(ref_out, 16'h0123);
		wr(`RFC_CTRL, 32'h1);
		set_code(3'h5);
		settle();
		chk(ref_out, 16'h0456);
		set_code(3'h7);
		settle();
		chk(ref_out, 16'h0799);
		wr(`RFC_CTRL, 32'h2);
		settle();
		chk(ref_out, 16'h0979);
		wr(`RFC_CTRL, 32'h0);
		wr(`RFC_BUSREF, 32'h0);
		wr(`RFC_SRCSEL, 32'h4);
		keys(3'b001);
		settle();
		keys(3'b100);
		repeat (40) @(posedge clk_sys);
		keys(3'b000);
		settle();
		rng(ref_out, 16'h0009, 16'h000B);
		keys(3'b010);
		repeat (20) @(posedge clk_sys);
		keys(3'b000);
		settle();
		rng(ref_out, 16'h0003, 16'h0007);
		keys(3'b001);
		settle();
		rd(`RFC_DIGIPOT, 16'h0000);
		keys(3'b000);
		wr(`RFC_SRCSEL, 32'h1);
		wr(`RFC_SP1, 32'h0200);
		set_fb(16'h0300, 16'h0100, 16'h0050);
		wr(`RFC_FBFN, 32'h1);
		settle();
		chk(fb_out, 16'h0100);
		chk(sp_out, 16'h0300);
		wr(`RFC_FBFN, 32'h2);
		settle();
		chk(fb_out, 16'h0050);
		for (i = 0; i < 5; i++) begin
			wr(`RFC_FBFN, {27'h0, fn[i]});
			settle();
			chk(fb_out, fx[i]);
			chk(sp_out, 16'h0200);
		end
		wr(`RFC_FBFN, 32'h43);
		settle();
		chk(fb_out, 16'h0450);
		wr(`RFC_SP1, 32'h0F00);
		wr(`RFC_SP2, 32'h0466);
		wr(`RFC_SP3, 32'h0100);
		set_fb(16'h0580, 16'h049A, 16'h0800);
		wr(`RFC_FBFN, 32'h0E);
		settle();
		chk({pair_idx, sp_out[13:0]}, 16'h4466);
		chk(fb_out, 16'h049A);
		wr(`RFC_FBFN, 32'h0D);
		settle();
		chk({14'h0, pair_idx}, 16'h0000);
		chk(sp_out, 16'h0F00);
		chk(fb_out, 16'h0580);
		wr(`RFC_FBFN, 32'h4E);
		settle();
		chk({14'h0, pair_idx}, 16'h0002);
		chk(fb_out, 16'h0800);
		wr(`RFC_FBFN, 32'h20);
		set_fb(16'h0400, 16'h0000, 16'h0000);
		settle();
		chk(fb_out, 16'h0200);
		set_fb(16'h0900, 16'h0000, 16'h0000);
		settle();
		rd(`RFC_FBOUT, 16'h0300);
		set_fb(16'hFF00, 16'h0000, 16'h0000);
		settle();
		chk(fb_out, 16'h0000);
		// low-pass with shift 1: a step arrives in halving increments
		set_fb(16'h0000, 16'h0000, 16'h0000);
		wr(`RFC_FBFN, 32'h100);
		settle();
		set_fb(16'h0400, 16'h0000, 16'h0000);
		repeat (4) @(posedge clk_sys);
		rng(fb_out, 16'h0100, 16'h0380);
		settle();
		settle();
		rng(fb_out, 16'h03F0, 16'h0400);
		close_out();
	end
endmodule
`default_nettype wire
